// ### rtl/adcrac_consts.vh
/*
  Constants of the converter control block: register offsets, field
  positions, reset values and conversion timing counts.
  Assumes inclusion by bare name from the design files of the block.
*/
// Contract
// - Mode register write adds one bus wait.
// - Channel register write adds one bus wait.
// - Mode or channel write may spoil result.
// - Result register read adds one bus wait.
// - Converter halts in standby; cleared bits save power.
`ifndef ADCRAC_CONSTS_VH
`define ADCRAC_CONSTS_VH

// ------------------------------------------------------------------
// Register byte offsets
// ------------------------------------------------------------------
`define ADCRAC_OFS_MODE      12'h000
`define ADCRAC_OFS_CHAN      12'h004
`define ADCRAC_OFS_RESULT    12'h008
`define ADCRAC_OFS_STATUS    12'h00C

// ------------------------------------------------------------------
// Register selects produced by the address decoder
// ------------------------------------------------------------------
`define ADCRAC_SEL_NONE      3'h0
`define ADCRAC_SEL_MODE      3'h1
`define ADCRAC_SEL_CHAN      3'h2
`define ADCRAC_SEL_RESULT    3'h3
`define ADCRAC_SEL_STATUS    3'h4

// ------------------------------------------------------------------
// Mode register fields
// ------------------------------------------------------------------
`define ADCRAC_MODE_RUN      7
`define ADCRAC_MODE_TS_HI    5
`define ADCRAC_MODE_TS_LO    3
`define ADCRAC_MODE_PWR      0
`define ADCRAC_MODE_RST      8'h00
`define ADCRAC_MODE_MASK     8'hB9

// ------------------------------------------------------------------
// Channel register fields
// ------------------------------------------------------------------
`define ADCRAC_CHAN_HI       1
`define ADCRAC_CHAN_RST      2'h0

// ------------------------------------------------------------------
// Status register fields
// ------------------------------------------------------------------
`define ADCRAC_STAT_BUSY     0
`define ADCRAC_STAT_DONE     1
`define ADCRAC_STAT_OVR      2

// ------------------------------------------------------------------
// Result and conversion timing
// ------------------------------------------------------------------
`define ADCRAC_RES_RST       10'h000
`define ADCRAC_RES_MSB       10'h200
`define ADCRAC_TPB0          7'h04
`define ADCRAC_TPB1          7'h06
`define ADCRAC_TPB2          7'h08
`define ADCRAC_TPB3          7'h0C
`define ADCRAC_TPB4          7'h10
`define ADCRAC_TPB5          7'h18
`define ADCRAC_TPB6          7'h20
`define ADCRAC_TPB7          7'h30

`endif

// ### rtl/adcrac_sar.v
/*
  Successive approximation sequencer: one sample phase of two bit
  periods, then ten bit trials from the top bit down.
  Assumes a comparator input already synchronised to pclk, high when
  the held input is at or above the trial code.
*/
`timescale 1ns/1ps
`include "adcrac_consts.vh"

module adcrac_sar (
  // Clock and reset
  input  wire       pclk,
  input  wire       presetn,
  // Control
  input  wire       start,
  input  wire       abort,
  input  wire [2:0] time_sel,
  input  wire       cmp_in,
  // Conversion outputs
  output reg        busy_q,
  output reg        sample_q,
  output reg  [9:0] dac_q,
  output reg        done_q,
  output reg  [9:0] result_q
);

  // ----------------------------------------------------------------
  // Bit period per time select
  // ----------------------------------------------------------------
  function [6:0] tpb;
    input [2:0] sel;
    begin
      case (sel)
        3'h0:    tpb = `ADCRAC_TPB0;
        3'h1:    tpb = `ADCRAC_TPB1;
        3'h2:    tpb = `ADCRAC_TPB2;
        3'h3:    tpb = `ADCRAC_TPB3;
        3'h4:    tpb = `ADCRAC_TPB4;
        3'h5:    tpb = `ADCRAC_TPB5;
        3'h6:    tpb = `ADCRAC_TPB6;
        default: tpb = `ADCRAC_TPB7;
      endcase
    end
  endfunction

  localparam ST_IDLE   = 2'h0;
  localparam ST_SAMPLE = 2'h1;
  localparam ST_CONV   = 2'h2;

  reg [1:0] state_q;
  reg [6:0] cnt_q;
  reg [6:0] period_q;
  reg [9:0] mask_q;
  wire [9:0] keep = cmp_in ? dac_q : (dac_q & ~mask_q);
  // Sample phase lasts two bit periods; the longest fits seven bits
  wire [7:0] first_cnt = {tpb(time_sel), 1'b0} - 8'h01;

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q  <= ST_IDLE;
      cnt_q    <= 7'h00;
      period_q <= `ADCRAC_TPB0;
      mask_q   <= 10'h000;
      busy_q   <= 1'b0;
      sample_q <= 1'b0;
      dac_q    <= `ADCRAC_RES_RST;
      done_q   <= 1'b0;
      result_q <= `ADCRAC_RES_RST;
    end else begin
      done_q <= 1'b0;
      if (abort) begin
        state_q  <= ST_IDLE;
        busy_q   <= 1'b0;
        sample_q <= 1'b0;
      end else begin
        case (state_q)
          ST_IDLE: begin
            if (start) begin
              state_q  <= ST_SAMPLE;
              period_q <= tpb(time_sel);
              cnt_q    <= first_cnt[6:0];
              busy_q   <= 1'b1;
              sample_q <= 1'b1;
            end
          end
          ST_SAMPLE: begin
            if (cnt_q == 7'h00) begin
              state_q  <= ST_CONV;
              sample_q <= 1'b0;
              dac_q    <= `ADCRAC_RES_MSB;
              mask_q   <= `ADCRAC_RES_MSB;
              cnt_q    <= period_q - 7'h01;
            end else begin
              cnt_q <= cnt_q - 7'h01;
            end
          end
          ST_CONV: begin
            if (cnt_q != 7'h00) begin
              cnt_q <= cnt_q - 7'h01;
            end else if (mask_q[0]) begin
              result_q <= keep;
              dac_q    <= keep;
              done_q   <= 1'b1;
              busy_q   <= 1'b0;
              state_q  <= ST_IDLE;
            end else begin
              dac_q  <= keep | (mask_q >> 1);
              mask_q <= mask_q >> 1;
              cnt_q  <= period_q - 7'h01;
            end
          end
          default: begin
            state_q <= ST_IDLE;
            busy_q  <= 1'b0;
          end
        endcase
      end
    end
  end

endmodule

// ### rtl/adcrac_top.v
/*
  Converter control block: APB register slave with mode, channel,
  result and status registers, wait insertion on the accesses that
  need it, standby gating and the conversion sequencer.
  Assumes an APB master on pclk, an analog comparator whose output
  is asynchronous to pclk, and a standby request on pclk.
*/
`timescale 1ns/1ps
`include "adcrac_consts.vh"

module adcrac_top (
  // Clock and reset
  input  wire        pclk,
  input  wire        presetn,
  // APB slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  // Power control
  input  wire        standby_req,
  // Analog front end
  input  wire        cmp_in,
  output wire        comparator_enable,
  output wire        sample_hold,
  output wire [9:0]  dac_code,
  output reg  [1:0]  analog_channel,
  output wire        conv_active
);

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  function [2:0] reg_sel;
    input [11:0] addr;
    begin
      case (addr)
        `ADCRAC_OFS_MODE:   reg_sel = `ADCRAC_SEL_MODE;
        `ADCRAC_OFS_CHAN:   reg_sel = `ADCRAC_SEL_CHAN;
        `ADCRAC_OFS_RESULT: reg_sel = `ADCRAC_SEL_RESULT;
        `ADCRAC_OFS_STATUS: reg_sel = `ADCRAC_SEL_STATUS;
        default:            reg_sel = `ADCRAC_SEL_NONE;
      endcase
    end
  endfunction

  // Accesses that take one extra access-phase cycle
  function needs_wait;
    input [2:0] sel;
    input       wr;
    begin
      case (sel)
        `ADCRAC_SEL_MODE:   needs_wait = wr;
        `ADCRAC_SEL_CHAN:   needs_wait = wr;
        `ADCRAC_SEL_RESULT: needs_wait = ~wr;
        default:            needs_wait = 1'b0;
      endcase
    end
  endfunction

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  reg  [7:0] mode_q;
  reg  [1:0] chan_q;
  reg        wait_q;
  reg        done_flag_q;
  reg        ovr_flag_q;
  reg  [9:0] res_q;
  reg        cmp_meta_q;
  reg        cmp_sync_q;

  wire [2:0] sel      = reg_sel(paddr);
  wire       access   = psel & penable;
  wire       wait_req = needs_wait(sel, pwrite);
  wire       xfer     = access & pready;
  wire       wr_mode  = xfer & pwrite & (sel == `ADCRAC_SEL_MODE);
  wire       wr_chan  = xfer & pwrite & (sel == `ADCRAC_SEL_CHAN);
  wire       rd_res   = xfer & ~pwrite & (sel == `ADCRAC_SEL_RESULT);
  wire       ctrl_wr  = wr_mode | wr_chan;

  wire       run_bit  = mode_q[`ADCRAC_MODE_RUN];
  wire       pwr_bit  = mode_q[`ADCRAC_MODE_PWR];
  wire [2:0] ts_field = mode_q[`ADCRAC_MODE_TS_HI:`ADCRAC_MODE_TS_LO];
  wire       enabled  = run_bit & pwr_bit & ~standby_req;

  wire       sar_busy;
  wire       sar_done;
  wire [9:0] sar_result;
  wire       sar_start = enabled & ~sar_busy & ~ctrl_wr;
  wire       sar_abort = ~enabled | ctrl_wr;

  // ----------------------------------------------------------------
  // Bus wait insertion
  // ----------------------------------------------------------------
  // First access cycle of a waited transfer holds pready low
  assign pready  = ~wait_req | wait_q;
  assign pslverr = access & (sel == `ADCRAC_SEL_NONE);

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wait_q <= 1'b0;
    end else if (xfer) begin
      wait_q <= 1'b0;
    end else if (access & wait_req) begin
      wait_q <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_q <= `ADCRAC_MODE_RST;
    end else if (wr_mode) begin
      // Time select is taken as written; software keeps it steady
      // while converting
      mode_q <= pwdata[7:0] & `ADCRAC_MODE_MASK;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      chan_q <= `ADCRAC_CHAN_RST;
    end else if (wr_chan) begin
      // Only the selection bits are stored
      chan_q <= pwdata[`ADCRAC_CHAN_HI:0];
    end
  end

  // Channel is frozen for the whole conversion
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      analog_channel <= `ADCRAC_CHAN_RST;
    end else if (sar_start) begin
      analog_channel <= chan_q;
    end
  end

  // ----------------------------------------------------------------
  // Result and status
  // ----------------------------------------------------------------
  // A control write restarts the sequencer; the held result is then
  // dropped, so software reads it before such a write
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      res_q <= `ADCRAC_RES_RST;
    end else if (sar_done) begin
      res_q <= sar_result;
    end else if (ctrl_wr) begin
      res_q <= `ADCRAC_RES_RST;
    end
  end

  // Completion wins over the clear of the done flag by a result read; for the overrun flag the read wins
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      done_flag_q <= 1'b0;
      ovr_flag_q  <= 1'b0;
    end else begin
      if (sar_done) begin
        done_flag_q <= 1'b1;
      end else if (rd_res | ctrl_wr) begin
        done_flag_q <= 1'b0;
      end
      if (sar_done & done_flag_q & ~rd_res) begin
        ovr_flag_q <= 1'b1;
      end else if (rd_res) begin
        ovr_flag_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Read data, loaded in the setup cycle
  // ----------------------------------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (psel & ~penable & ~pwrite) begin
      case (sel)
        `ADCRAC_SEL_MODE:   prdata <= {24'h000000, mode_q};
        `ADCRAC_SEL_CHAN:   prdata <= {30'h00000000, chan_q};
        `ADCRAC_SEL_RESULT: prdata <= {22'h000000, res_q};
        `ADCRAC_SEL_STATUS: prdata <= {29'h00000000, ovr_flag_q,
                                       done_flag_q, sar_busy};
        default:            prdata <= 32'h00000000;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Comparator synchroniser
  // ----------------------------------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmp_meta_q <= 1'b0;
      cmp_sync_q <= 1'b0;
    end else begin
      cmp_meta_q <= cmp_in;
      cmp_sync_q <= cmp_meta_q;
    end
  end

  // ----------------------------------------------------------------
  // Power gating and sequencer
  // ----------------------------------------------------------------
  // Standby stops conversion and drops the comparator supply
  assign comparator_enable = pwr_bit & ~standby_req;
  assign conv_active       = sar_busy;

  adcrac_sar u_sar (
    .pclk     (pclk),
    .presetn  (presetn),
    .start    (sar_start),
    .abort    (sar_abort),
    .time_sel (ts_field),
    .cmp_in   (cmp_sync_q),
    .busy_q   (sar_busy),
    .sample_q (sample_hold),
    .dac_q    (dac_code),
    .done_q   (sar_done),
    .result_q (sar_result)
  );

endmodule

// ### bench/adcrac_top_assertions.sv
/*
  Port checker of adcrac_top: wait insertion, error answers,
  standby halt and channel latching.
  Assumes it is bound onto adcrac_top, one pclk domain.
*/
`timescale 1ns/1ps

module adcrac_top_assertions (
  // Clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // APB slave
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // Power and analog side
  input wire logic        standby_req,
  input wire logic        cmp_in,
  input wire logic        comparator_enable,
  input wire logic        sample_hold,
  input wire logic [9:0]  dac_code,
  input wire logic [1:0]  analog_channel,
  input wire logic        conv_active
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // ------------------------------------------------------------
  // Transfer steps
  // ------------------------------------------------------------
  sequence s_setup(logic [11:0] a, logic wr);
    psel && !penable && paddr == a && pwrite == wr;
  endsequence
  sequence s_one_wait;
    !pready ##1 pready;
  endsequence

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  a_mode_write_wait: assert property (
    s_setup(12'h000, 1'b1) |=> s_one_wait)
    else $error("mode write not stalled one cycle");
  a_chan_write_wait: assert property (
    s_setup(12'h004, 1'b1) |=> s_one_wait)
    else $error("channel write not stalled one cycle");
  a_result_read_wait: assert property (
    s_setup(12'h008, 1'b0) |=> s_one_wait)
    else $error("result read not stalled one cycle");
  a_status_no_wait: assert property (
    s_setup(12'h00C, 1'b0) |=> pready)
    else $error("status read stalled");
  a_unmapped_error: assert property (
    psel && penable && paddr >= 12'h010 |-> pslverr)
    else $error("unmapped access without error");
  a_error_in_access: assert property (
    pslverr |-> psel && penable)
    else $error("error outside access phase");
  a_standby_halts: assert property (
    standby_req |-> !comparator_enable ##1 !$rose(conv_active))
    else $error("converter active in standby");
  a_chan_at_conv: assert property (
    $changed(analog_channel) |-> conv_active)
    else $error("channel changed outside conversion");
endmodule

// ### bench/test_adc_register_access_control.sv
/*
  Self-checking bench of adcrac_top driven over APB.
  Assumes the checker file is compiled before this one.
*/
`timescale 1ns/1ps

bind adcrac_top adcrac_top_assertions u_adcrac_top_assertions (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .standby_req(standby_req),
  .cmp_in(cmp_in), .comparator_enable(comparator_enable),
  .sample_hold(sample_hold), .dac_code(dac_code),
  .analog_channel(analog_channel), .conv_active(conv_active));

module test_adc_register_access_control;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic        standby_req = 1'b0, cmp_in = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, rd;
  logic        err, cv;
  logic [1:0]  ch;
  wire  [31:0] prdata;
  wire         pready, pslverr, comparator_enable, sample_hold;
  wire         conv_active;
  wire  [9:0]  dac_code;
  wire  [1:0]  analog_channel;
  integer      n_errors = 0, n_compared = 0, w, i, k;

  always #25 pclk = ~pclk;

  adcrac_top u_adcrac_top (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .standby_req(standby_req),
    .cmp_in(cmp_in), .comparator_enable(comparator_enable),
    .sample_hold(sample_hold), .dac_code(dac_code),
    .analog_channel(analog_channel), .conv_active(conv_active));

  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value at %0t: saw %h, expected %h",
               $time, seen, exp);
    end
  endtask

  // Mode read back: run, time select and comparator power bits only
  function automatic logic [31:0] exp_mode(input integer ts);
    return {24'h000000, 1'b1, 1'b0, 3'(ts), 2'b00, 1'b1};
  endfunction

  // A comparator held high through every trial keeps every bit
  function automatic logic [31:0] exp_res(input logic c);
    return c ? 32'h000003FF : 32'h00000000;
  endfunction

  task final_report;
    if (n_errors == 0 && n_compared > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // One transfer; w counts wait cycles, rd and err hold the answer
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    w = 0;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      w++;
      @(posedge pclk);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task wait_done;
    k = 0;
    do begin
      apb(1'b0, 12'h00C, 32'h0);
      k++;
    end while (rd[1] !== 1'b1 && k < 300);
    chk(rd[1], 1'b1);
  endtask

  // ------------------------------------------------------------
  // Tests
  // ------------------------------------------------------------
  initial begin
    i = $urandom(32'h8136);
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b1, 12'h008, 32'h3FF);
    chk(w, 0);
    for (i = 0; i < 4; i++) begin
      apb(1'b0, 12'(i * 4), 32'h0);
      chk(rd, 32'h0);
      chk(w, i == 2);
    end
    apb(1'b0, 12'h010, 32'h0);
    chk(err, 1'b1);
    chk(rd, 32'h0);
    apb(1'b1, 12'h014, 32'h5A);
    chk(err, 1'b1);
    for (i = 0; i < 8; i++) begin
      ch = 2'($urandom);
      cv = 1'($urandom);
      cmp_in <= cv;
      apb(1'b1, 12'h004, {30'h0, ch});
      chk(w, 1);
      apb(1'b1, 12'h000, 32'h81 | (i << 3));
      chk(w, 1);
      apb(1'b0, 12'h000, 32'h0);
      chk(rd, exp_mode(i));
      wait_done;
      chk(analog_channel, ch);
      apb(1'b0, 12'h008, 32'h0);
      chk(rd, exp_res(cv));
      chk(w, 1);
      // Standby keeps a finishing conversion off the control write
      standby_req <= 1'b1;
      apb(1'b1, 12'h000, 32'h01 | (i << 3));
      apb(1'b0, 12'h008, 32'h0);
      chk(rd, 32'h0);
      apb(1'b0, 12'h00C, 32'h0);
      chk(rd, 32'h0);
      standby_req <= 1'b0;
    end
    apb(1'b1, 12'h000, 32'h81);
    standby_req <= 1'b1;
    repeat (100) @(posedge pclk);
    chk({conv_active, comparator_enable, sample_hold}, 3'b000);
    standby_req <= 1'b0;
    repeat (3) @(posedge pclk);
    chk({conv_active, comparator_enable, sample_hold}, 3'b111);
    // Sample phase is two bit periods, then the top bit is tried
    repeat (8) @(posedge pclk);
    chk({sample_hold, dac_code}, {1'b0, 10'h200});
    presetn <= 1'b0;
    @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, 12'h000, 32'h0);
    chk(rd, 32'h0);
    chk({conv_active, sample_hold, dac_code, analog_channel}, 32'h0);
    final_report;
  end

  initial begin
    #2500000;
    n_errors++;
    final_report;
  end
endmodule
